//--- msad_byte_adder.sv
// Purpose: Eight-bit adder with nibble carry, carry and overflow
// Assumes: Purely combinational
// Notes: Shared by immediate add and byte add
`timescale 1ns/1ns
module msad_byte_adder (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  output logic [7:0] sum,
  output logic c4,
  output logic c8,
  output logic v
);
  logic [4:0] lo; // Low nibble sum
  logic [8:0] full; // Full sum with carry

  // Add and derive carries
  always_comb begin
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    full = {1'b0, a} + {1'b0, b};
    sum = full[7:0];
    c4 = lo[4];
    c8 = full[8];
    v = (a[7] == b[7]) && (full[7] != a[7]);
  end
endmodule : msad_byte_adder

//--- msad_datapath.sv
// Purpose: Byte-wide shift/add datapath slice with AXI4-Lite access
// Assumes: Sequencer writes control words to CTRL
// Notes: CTRL write launches; busy until the op ends
`timescale 1ns/1ns
module msad_datapath
  import msad_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic negative_byte_flag,
  output logic zero_byte_flag,
  output logic half_carry_flag,
  output logic byte_carry_flag,
  output logic cc_n,
  output logic cc_z,
  output logic cc_v,
  output logic cc_c,
  output logic busy
);
  // Whole module state
  typedef struct packed {
    msad_phase_t ph; // Execution phase
    logic [15:0] mi; // Current control word
    logic ind; // Indirect A select
    logic [3:0] iptr; // Indirect pointer
    logic nb;
    logic zb;
    logic c4;
    logic c8;
    logic n;
    logic z;
    logic v;
    logic c;
    logic unsup; // Last word not handled
    logic [15:0][7:0] rf; // Byte register file
    logic aw_got; // Write address held
    logic w_got; // Write data held
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } msad_state_t;

  msad_state_t s; // Registered state
  msad_state_t next_s; // Next state

  logic is_srw; // Plain word shift
  logic is_shift_right_word_carry_in; // Carry-in word shift
  logic is_ab; // Add byte
  logic is_lit; // Literal group
  logic is_al; // Immediate add
  logic [3:0] a_fld; // A selector
  logic [3:0] b_fld; // B selector
  logic [3:0] a_cur; // A byte this phase
  logic [3:0] b_cur; // B byte this phase
  logic [7:0] a_byte; // A operand
  logic [7:0] b_byte; // B operand
  logic [7:0] add_b; // Second adder input
  logic [7:0] sum; // Adder result
  logic sum_c4;
  logic sum_c8;
  logic sum_v;

  // Decode of the held control word
  assign is_srw = s.mi[15:9] == MSAD_OP_SRW;
  assign is_shift_right_word_carry_in = s.mi[15:9] == MSAD_OP_SHIFT_RIGHT_WORD_CARRY_IN;
  assign is_ab = s.mi[15:9] == MSAD_OP_AB;
  assign is_lit = (s.mi[15:12] >= MSAD_LIT_LO) && (s.mi[15:12] <= MSAD_LIT_HI);
  assign is_al = s.mi[15:12] == MSAD_LIT_ADD;

  // A selector direct or through the pointer, B selector direct
  assign a_fld = (is_lit && s.ind) ? s.iptr : s.mi[3:0];
  assign b_fld = s.mi[7:4];

  // Second phase uses the even (low) byte of the pair
  assign a_cur = (s.ph == MSAD_SECOND) ? {a_fld[3:1], 1'b0} : a_fld;
  assign b_cur = (s.ph == MSAD_SECOND) ? {b_fld[3:1], 1'b0} : b_fld;
  assign a_byte = s.rf[a_cur];
  assign b_byte = s.rf[b_cur];

  // Literal field or B byte as addend
  assign add_b = is_al ? s.mi[11:4] : b_byte;

  msad_byte_adder u_add (
    .a(a_byte),
    .b(add_b),
    .sum(sum),
    .c4(sum_c4),
    .c8(sum_c8),
    .v(sum_v)
  );

  // Bus handshakes
  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready = !s.w_got && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;

  // Flag outputs straight from state
  assign negative_byte_flag = s.nb;
  assign zero_byte_flag = s.zb;
  assign half_carry_flag = s.c4;
  assign byte_carry_flag = s.c8;
  assign cc_n = s.n;
  assign cc_z = s.z;
  assign cc_v = s.v;
  assign cc_c = s.c;
  assign busy = s.ph != MSAD_IDLE;

  // Next-state logic
  always_comb begin
    logic [7:0] res; // Shift result byte
    res = 8'h00;
    next_s = s;

    // Write address and data captured in either order
    if (s_axi_awvalid && s_axi_awready) begin
      next_s.aw_got = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Write commits only while idle
    if (s.aw_got && s.w_got && !s.bvalid && s.ph == MSAD_IDLE) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = MSAD_RESP_OKAY;
      if (s.awaddr == MSAD_ADDR_CTRL) begin
        // Load control word and launch
        if (s.wstrb[0]) begin
          next_s.mi[7:0] = s.wdata[7:0];
        end
        if (s.wstrb[1]) begin
          next_s.mi[15:8] = s.wdata[15:8];
        end
        if (s.wstrb[2]) begin
          next_s.ind = s.wdata[MSAD_CTRL_IND_BIT];
        end
        next_s.unsup = 1'b0;
        next_s.ph = MSAD_FIRST;
      end else if (s.awaddr == MSAD_ADDR_STAT) begin
        // Software preset of the flags
        if (s.wstrb[0]) begin
          {next_s.nb, next_s.zb, next_s.c4, next_s.c8} = s.wdata[7:4];
          {next_s.n, next_s.z, next_s.v, next_s.c} = s.wdata[3:0];
        end
      end else if (s.awaddr == MSAD_ADDR_IPTR) begin
        // Indirect pointer
        if (s.wstrb[0]) begin
          next_s.iptr = s.wdata[3:0];
        end
      end else if (s.awaddr >= MSAD_ADDR_RF && s.awaddr < MSAD_ADDR_RF_END) begin
        // Register file byte
        if (s.wstrb[0]) begin
          next_s.rf[s.awaddr[5:2]] = s.wdata[7:0];
        end
      end else begin
        // Unmapped
        next_s.bresp = MSAD_RESP_SLVERR;
      end
    end

    // Read channel
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = MSAD_RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      if (s_axi_araddr == MSAD_ADDR_CTRL) begin
        next_s.rdata[15:0] = s.mi;
        next_s.rdata[MSAD_CTRL_IND_BIT] = s.ind;
      end else if (s_axi_araddr == MSAD_ADDR_STAT) begin
        // Flags, busy and unhandled-op indication
        next_s.rdata[7:0] = {s.nb, s.zb, s.c4, s.c8, s.n, s.z, s.v, s.c};
        next_s.rdata[MSAD_STAT_BUSY_BIT] = s.ph != MSAD_IDLE;
        next_s.rdata[MSAD_STAT_UNSUP_BIT] = s.unsup;
      end else if (s_axi_araddr == MSAD_ADDR_IPTR) begin
        next_s.rdata[3:0] = s.iptr;
      end else if (s_axi_araddr >= MSAD_ADDR_RF && s_axi_araddr < MSAD_ADDR_RF_END) begin
        next_s.rdata[7:0] = s.rf[s_axi_araddr[5:2]];
      end else begin
        next_s.rresp = MSAD_RESP_SLVERR;
      end
    end

    // Microinstruction execution
    unique case (s.ph)
      MSAD_IDLE: begin
        // Waiting for a control word
      end
      MSAD_FIRST: begin
        next_s.ph = MSAD_IDLE;
        if (is_srw || is_shift_right_word_carry_in) begin
          // Upper byte: fill bit is zero or C
          res = {(is_shift_right_word_carry_in ? s.c : 1'b0), b_byte[7:1]};
          next_s.rf[a_cur] = res;
          next_s.nb = res[7];
          next_s.zb = res == 8'h00;
          next_s.c8 = b_byte[0];
          next_s.ph = MSAD_SECOND;
        end else if (is_al) begin
          // Immediate add, codes untouched
          next_s.rf[a_cur] = sum;
          next_s.nb = sum[7];
          next_s.zb = sum == 8'h00;
          next_s.c4 = sum_c4;
          next_s.c8 = sum_c8;
        end else if (is_ab) begin
          // Byte add; B byte never written
          next_s.rf[a_cur] = sum;
          next_s.nb = sum[7];
          next_s.zb = sum == 8'h00;
          next_s.c4 = sum_c4;
          next_s.c8 = sum_c8;
          if (s.mi[MSAD_MI_FLAG_BIT]) begin
            // Odd opcode also updates codes
            next_s.n = sum[7];
            next_s.z = sum == 8'h00;
            next_s.v = sum_v;
            next_s.c = sum_c8;
          end
        end else begin
          // Other opcodes: only the unhandled-op bit is set
          next_s.unsup = 1'b1;
        end
      end
      MSAD_SECOND: begin
        // Lower byte: top bit from upper half via C8
        res = {s.c8, b_byte[7:1]};
        next_s.rf[a_cur] = res;
        next_s.zb = s.zb && (res == 8'h00);
        next_s.c8 = b_byte[0];
        if (s.mi[MSAD_MI_FLAG_BIT]) begin
          // Word result codes; V kept
          next_s.n = s.nb;
          next_s.z = s.zb && (res == 8'h00);
          next_s.c = b_byte[0];
        end
        next_s.ph = MSAD_IDLE;
      end
      default: begin
        // Illegal code recovers to idle
        next_s.ph = MSAD_IDLE;
      end
    endcase
  end

  // State register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.ph <= MSAD_IDLE;
      s.mi <= MSAD_MI_RST;
      s.iptr <= MSAD_IPTR_RST;
      {s.nb, s.zb, s.c4, s.c8, s.n, s.z, s.v, s.c} <= MSAD_FLAGS_RST;
    end else begin
      s <= next_s;
    end
  end
endmodule : msad_datapath

//--- msad_datapath_chk.sv
// Purpose: Port checks for the shift/add datapath
// Assumes: One clock, synchronous active-low reset
// Notes: Last write beat is kept to decode launches
`timescale 1ns/1ns
module msad_datapath_chk
  import msad_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic half_carry_flag,
  input wire logic cc_n,
  input wire logic cc_z,
  input wire logic cc_v,
  input wire logic cc_c,
  input wire logic busy
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [11:0] wa; // Last write address
  logic [15:0] wd; // Low half of last write data, any address
  logic ctl, shf, lit, byt;
  // Keep each write beat
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[15:0];
  end
  assign ctl = wa == MSAD_ADDR_CTRL;
  assign shf = ctl && (wd[15:9] == MSAD_OP_SRW || wd[15:9] == MSAD_OP_SHIFT_RIGHT_WORD_CARRY_IN);
  assign lit = ctl && wd[15:12] == MSAD_LIT_ADD;
  assign byt = lit || (ctl && wd[15:9] == MSAD_OP_AB);
  // Control word accepted
  sequence s_launch;
    $rose(s_axi_bvalid) && ctl;
  endsequence
  a_launch_busy: assert property (s_launch ##0 (shf || byt) |-> busy)
    else $error("busy missing at launch");
  a_byte_one: assert property (s_launch ##0 byt |=> !busy)
    else $error("byte op too long");
  a_word_two: assert property (s_launch ##0 shf |-> busy ##1 busy ##1 !busy)
    else $error("word op not two cycles");
  a_shift_keep: assert property (s_launch ##0 shf |-> ##2 (half_carry_flag == $past(half_carry_flag, 2)))
    else $error("half carry changed");
  a_shift_v: assert property (s_launch ##0 shf |-> ##2 (cc_v == $past(cc_v, 2)))
    else $error("overflow changed");
  a_lit_codes: assert property (s_launch ##0 lit |=> $stable({cc_n, cc_z, cc_v, cc_c}))
    else $error("codes changed by literal add");
  a_busy_max: assert property (busy |-> ##[1:2] !busy)
    else $error("busy too long");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("response dropped");
  a_reset_idle: assert property (disable iff (1'b0) !aresetn |=> !busy && !s_axi_bvalid && !cc_c && !half_carry_flag)
    else $error("not idle after reset");
endmodule : msad_datapath_chk
bind msad_datapath msad_datapath_chk u_msad_datapath_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .half_carry_flag,
  .cc_n, .cc_z, .cc_v, .cc_c, .busy);

//--- msad_pkg.sv
// Purpose: Shared constants and types for the shift/add datapath slice
// Assumes: AXI4-Lite register access, 20 MHz microcycle clock
// Notes: Operation list follows
// Operation
// - Shift word pair right into destination pair
// - Flag variant also loads C with shifted bit
// - Carry variant inserts C at top bit
// - Carry flag variant updates codes, C from shift
// - Word shifts set NB, ZB, C8; keep C4
// - Flag word shifts set N, Z; keep V
// - Add immediate literal bits 11:4 to A byte
// - Immediate add leaves condition codes alone
// - Byte adds set C4 and C8 carries
// - Byte ops set NB and ZB from result
// - Add byte B into A, B unchanged
// - Add byte flags variant sets N Z V C
// - Literal group is top nibble 2 to 6
// - Literal A field selects byte, direct/indirect
// - Literal ops finish in one microcycle
// - Word ops take two byte microcycles
// - Status flags refresh on every byte op
// - Odd opcode also updates condition codes
package msad_pkg;
  // Register byte addresses
  localparam logic [11:0] MSAD_ADDR_CTRL = 12'h000;
  localparam logic [11:0] MSAD_ADDR_STAT = 12'h004;
  localparam logic [11:0] MSAD_ADDR_IPTR = 12'h008;
  localparam logic [11:0] MSAD_ADDR_RF = 12'h040;
  localparam logic [11:0] MSAD_ADDR_RF_END = 12'h080;
  // Field positions
  localparam int MSAD_CTRL_IND_BIT = 16;
  localparam int MSAD_STAT_BUSY_BIT = 8;
  localparam int MSAD_STAT_UNSUP_BIT = 9;
  localparam int MSAD_MI_FLAG_BIT = 8;
  // Reset values
  localparam logic [15:0] MSAD_MI_RST = 16'h0000;
  localparam logic [3:0] MSAD_IPTR_RST = 4'h0;
  localparam logic [7:0] MSAD_FLAGS_RST = 8'h00;
  // Opcode decodes (control word bits 15:9)
  localparam logic [6:0] MSAD_OP_SRW = 7'h6f;
  localparam logic [6:0] MSAD_OP_SHIFT_RIGHT_WORD_CARRY_IN = 7'h6d;
  localparam logic [6:0] MSAD_OP_AB = 7'h50;
  // Literal group nibble range and the immediate add
  localparam logic [3:0] MSAD_LIT_LO = 4'h2;
  localparam logic [3:0] MSAD_LIT_HI = 4'h6;
  localparam logic [3:0] MSAD_LIT_ADD = 4'h2;
  // Timing: one microcycle is one clock
  localparam int MSAD_CLK_NS = 50;
  localparam int MSAD_LIT_CYCLES = 1;
  // AXI responses
  localparam logic [1:0] MSAD_RESP_OKAY = 2'h0;
  localparam logic [1:0] MSAD_RESP_SLVERR = 2'h2;
  // Execution phases, Gray coded
  typedef enum logic [1:0] {
    MSAD_IDLE = 2'h0,
    MSAD_FIRST = 2'h1,
    MSAD_SECOND = 2'h3
  } msad_phase_t;
endpackage : msad_pkg

//--- msad_seq_model.sv
// Purpose: Sequencer model issuing control words over AXI4-Lite
// Assumes: One transfer at a time, changes right after rising edges
// Notes: The bench calls its tasks
`timescale 1ns/1ns
module msad_seq_model (
  input wire logic aclk,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // Idle bus from time zero
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // Write: address and data together, each dropped when taken
  // Nonzero hold keeps bready low that many cycles after the response shows
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r, input int hold = 0);
    logic ap;
    logic dp;
    ap = 1'b1;
    dp = 1'b1;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    s_axi_bready <= (hold == 0);
    while (ap || dp) begin
      @(posedge aclk);
      if (ap && s_axi_awready) begin
        ap = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (dp && s_axi_wready) begin
        dp = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge aclk);
    // Late ready: response must stand until it is taken
    if (hold != 0) begin
      repeat (hold - 1) @(posedge aclk);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  // Read: hold request until taken, ready until data
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge aclk);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : msad_seq_model

//--- tb.sv
// Purpose: Self-checking bench for the shift/add datapath
// Assumes: B selector 3 (pair 3:2), A selector 5 (pair 5:4)
// Notes: Table rows first, then hand cases
`timescale 1ns/1ns
module tb;
  import msad_pkg::*;
  typedef struct packed {
    logic [15:0] ctrl, src, dst;
    logic [7:0] st;
    logic [15:0] exp_dst;
    logic [7:0] exp_st;
  } msad_row_t;
  // Control word, source, destination, flag preset, results; odd selectors
  localparam msad_row_t ROWS [9] = '{
    '{16'hde35, 16'h8003, 16'h0000, 8'h23, 16'h4001, 8'h33}, '{16'hdf35, 16'h0001, 16'hffff, 8'h2a, 16'h0000, 8'h77},
    '{16'hda35, 16'h0002, 16'h0000, 8'h01, 16'h8001, 8'h81}, '{16'hdb35, 16'h0003, 16'h0000, 8'h0e, 16'h0001, 8'h13},
    '{16'h2805, 16'h0000, 16'h8855, 8'h0f, 16'h0855, 8'h1f}, '{16'h2015, 16'h0000, 16'hff00, 8'h00, 16'h0000, 8'h70},
    '{16'ha035, 16'h0100, 16'h7f00, 8'h05, 16'h8000, 8'ha5}, '{16'ha135, 16'h0100, 16'h7f00, 8'h00, 16'h8000, 8'haa},
    '{16'ha135, 16'h0100, 16'hff00, 8'h00, 16'h0000, 8'h75}};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, busy, cc_n, cc_z, cc_v, cc_c;
  logic negative_byte_flag, zero_byte_flag, half_carry_flag, byte_carry_flag;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] flags;
  int error_cnt = 0, comparisons = 0, cyc = 0;
  assign flags = {negative_byte_flag, zero_byte_flag, half_carry_flag, byte_carry_flag, cc_n, cc_z, cc_v, cc_c};
  msad_datapath u_msad_datapath (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .negative_byte_flag,
    .zero_byte_flag, .half_carry_flag, .byte_carry_flag, .cc_n, .cc_z, .cc_v, .cc_c, .busy);
  msad_seq_model u_msad_seq_model (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // 50 ns clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] a);
    comparisons++;
    if (a !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, a);
    end
  endtask : chk
  // Register write expecting OKAY
  task automatic w(input logic [11:0] a, input logic [31:0] d);
    u_msad_seq_model.wr(a, d, rsp);
    chk("bresp", 32'(MSAD_RESP_OKAY), 32'(rsp));
  endtask : w
  // Byte pair in the register file, low byte first
  task automatic wrf(input int i, input logic [15:0] v);
    for (int k = 0; k < 2; k++) w(MSAD_ADDR_RF + 12'(4 * (i + k)), 32'(v[8 * k +: 8]));
  endtask : wrf
  task automatic rrf(input int i, input logic [15:0] e);
    for (int k = 0; k < 2; k++) begin
      u_msad_seq_model.rd(MSAD_ADDR_RF + 12'(4 * (i + k)), rd_v, rsp);
      chk("reg byte", 32'(e[8 * k +: 8]), rd_v);
    end
  endtask : rrf
  // Bounded wait for idle, then sample settled flags
  task automatic settle;
    for (int n = 0; n < 8 && busy !== 1'b0; n++) @(posedge aclk);
    @(negedge aclk);
  endtask : settle
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      $display("[ERR] run length expected below 20000 seen %0d", cyc);
      results();
    end
  end
  initial begin
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("reset flags", 32'h0, 32'(flags));
    foreach (ROWS[i]) begin
      wrf(2, ROWS[i].src);
      wrf(4, ROWS[i].dst);
      w(MSAD_ADDR_STAT, 32'(ROWS[i].st));
      w(MSAD_ADDR_CTRL, 32'(ROWS[i].ctrl));
      settle();
      chk("flags", 32'(ROWS[i].exp_st), 32'(flags));
      rrf(4, ROWS[i].exp_dst);
      rrf(2, ROWS[i].src);
    end
    // Back-to-back word shifts: second commits after first ends, inherits carry
    wrf(2, 16'h0001);
    w(MSAD_ADDR_STAT, 32'h0);
    w(MSAD_ADDR_CTRL, 32'hdf35);
    w(MSAD_ADDR_CTRL, 32'hda35);
    settle();
    chk("chained flags", 32'h95, 32'(flags));
    rrf(4, 16'h8000);
    // Indirect target through the pointer
    u_msad_seq_model.wr(MSAD_ADDR_IPTR, 32'h7, rsp, 2);
    chk("late bready bresp", 32'(MSAD_RESP_OKAY), 32'(rsp));
    wrf(6, 16'h1000);
    w(MSAD_ADDR_CTRL, 32'h12015);
    settle();
    rrf(6, 16'h1100);
    // Other literal-group codes only set the unhandled-op bit
    w(MSAD_ADDR_STAT, 32'h5a);
    for (int k = 3; k < 7; k++) w(MSAD_ADDR_CTRL, {16'h0, k[3:0], 12'h005});
    settle();
    u_msad_seq_model.rd(MSAD_ADDR_STAT, rd_v, rsp);
    chk("stat", 32'h25a, rd_v);
    rrf(4, 16'h8000);
    // Unmapped place
    u_msad_seq_model.wr(12'h00c, 32'h1, rsp);
    chk("unmapped bresp", 32'(MSAD_RESP_SLVERR), 32'(rsp));
    u_msad_seq_model.rd(12'h00c, rd_v, rsp);
    chk("unmapped rresp", 32'(MSAD_RESP_SLVERR), 32'(rsp));
    // Mid-run reset clears flags, status and register file
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("reset busy", 32'h0, 32'(busy));
    chk("mid reset flags", 32'h0, 32'(flags));
    u_msad_seq_model.rd(MSAD_ADDR_STAT, rd_v, rsp);
    chk("reset stat", 32'h0, rd_v);
    rrf(4, 16'h0000);
    results();
  end
endmodule : tb
